//--- core/ffagg_pkg.sv
// Package with constants and field layouts of the fault flag aggregator.
package ffagg_pkg;

	// Temperature trip point select codes and their limits in degrees Celsius.
	localparam logic [1:0] FFAGG_TRIP_142 = 2'h0;
	localparam logic [1:0] FFAGG_TRIP_127 = 2'h1;
	localparam logic [1:0] FFAGG_TRIP_112 = 2'h2;
	localparam logic [1:0] FFAGG_TRIP_97  = 2'h3;
	localparam int FFAGG_LIMIT_142_C = 142;
	localparam int FFAGG_LIMIT_127_C = 127;
	localparam int FFAGG_LIMIT_112_C = 112;
	localparam int FFAGG_LIMIT_97_C  = 97;
	localparam logic [1:0] FFAGG_TRIP_RST = 2'h0;

	// Bit position of the serial diagnostic quiet bit in general_setup_one.
	localparam int FFAGG_QUIET_BIT = 3;

	// Digital flag positions.
	localparam int FFAGG_DIG_W       = 16;
	localparam int FFAGG_D_OSC_STOP  = 0;
	localparam int FFAGG_D_CAL_UNREF = 1;
	localparam int FFAGG_D_RESET_DET = 2;
	localparam int FFAGG_D_TW_IF     = 3;
	localparam int FFAGG_D_WDT       = 4;
	localparam int FFAGG_D_TW_PAR    = 5;
	localparam int FFAGG_D_LATCH     = 6;
	localparam int FFAGG_D_INV_CHK   = 7;
	localparam int FFAGG_D_CAL_CRC   = 8;
	localparam int FFAGG_D_INV_ACC   = 9;
	localparam int FFAGG_D_SCLK_CNT  = 10;
	localparam int FFAGG_D_SLIP      = 11;
	localparam int FFAGG_D_SER_CRC   = 12;
	localparam int FFAGG_D_SLEW_BUSY = 13;

	// Analog flag positions.
	localparam int FFAGG_ANA_W       = 16;
	localparam int FFAGG_A_REFERENCE_INPUT     = 0;
	localparam int FFAGG_A_REFERENCE_OUTPUT    = 1;
	localparam int FFAGG_A_LDO       = 2;
	localparam int FFAGG_A_AVCC      = 3;
	localparam int FFAGG_A_DIE_MAIN  = 4;
	localparam int FFAGG_A_DIE_DCDC  = 5;
	localparam int FFAGG_A_OVERVOLT  = 6;
	localparam int FFAGG_A_DCDC_SC   = 7;
	localparam int FFAGG_A_DCDC_PWR  = 8;
	localparam int FFAGG_A_IOUT_OC   = 9;
	localparam int FFAGG_A_VOUT_SC   = 10;

	// Sources that reach the fault line and may be masked.
	localparam logic [FFAGG_DIG_W-1:0] FFAGG_DIG_MASKABLE = 16'h1ad1;
	// Sources that reach the fault line and no fault mask bit can mask; the quiet bit still blocks FFAGG_D_SCLK_CNT.
	localparam logic [FFAGG_DIG_W-1:0] FFAGG_DIG_FORCED   = 16'h0528;
	localparam logic [FFAGG_ANA_W-1:0] FFAGG_ANA_MASKABLE = 16'h06f0;
	localparam logic [FFAGG_ANA_W-1:0] FFAGG_ANA_FORCED   = 16'h010f;
	// Flags that clear by themselves instead of by write one to clear.
	localparam logic [FFAGG_DIG_W-1:0] FFAGG_DIG_SELF_CLR = 16'h2002;
	// Comparator sourced analog flags that pass a synchroniser.
	localparam logic [FFAGG_ANA_W-1:0] FFAGG_ANA_COMP     = 16'h003f;
	// Reset detected flag is set on reset.
	localparam logic [FFAGG_DIG_W-1:0] FFAGG_DIG_RST      = 16'h0004;
	localparam logic [FFAGG_ANA_W-1:0] FFAGG_ANA_RST      = 16'h0000;
	localparam logic [FFAGG_DIG_W-1:0] FFAGG_MASK_RST     = 16'h0000;

endpackage

//--- core/ffagg_sync.sv
// Two flip-flop synchroniser for a vector of asynchronous levels.
`timescale 1ns/1ps
`default_nettype none
module ffagg_sync #(
	parameter int W = 16
) (
	// Clock and control.
	input  wire logic         clk_sys,
	input  wire logic         srst,
	input  wire logic         clk_en,
	// Levels.
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);

	logic [W-1:0] meta_q;
	logic [W-1:0] meta_d;
	logic [W-1:0] sync_q;
	logic [W-1:0] sync_d;

	always_comb begin
		meta_d = meta_q;
		sync_d = sync_q;
		if (srst) begin
			meta_d = '0;
			sync_d = '0;
		end else if (clk_en) begin
			meta_d = async_in;
			sync_d = meta_q;
		end
	end

	always_ff @(posedge clk_sys) begin
		meta_q <= meta_d;
		sync_q <= sync_d;
	end

	assign sync_out = sync_q;

endmodule
`default_nettype wire

//--- core/ffagg_core.sv
// Fault flag aggregator: sticky diagnostic flags and the shared fault line.
`timescale 1ns/1ps
`default_nettype none
module ffagg_core
	import ffagg_pkg::*;
#(
	parameter int DW = FFAGG_DIG_W,
	parameter int AW = FFAGG_ANA_W
) (
	// Clock, reset and enable.
	input  wire logic          clk_sys,
	input  wire logic          srst,
	input  wire logic          clk_en,
	// Configuration.
	input  wire logic [1:0]    trip_select,
	input  wire logic          serial_diag_quiet,
	input  wire logic          comparator_enable,
	input  wire logic [DW-1:0] fault_mask_dig,
	input  wire logic [AW-1:0] fault_mask_ana,
	// Asynchronous comparator levels from the analog circuitry.
	input  wire logic          temp_main_over,
	input  wire logic          temp_dcdc_over,
	input  wire logic [3:0]    supply_out_of_window,
	// Synchronous fault sources, level while the condition stands.
	input  wire logic [DW-1:0] dig_fault_in,
	input  wire logic [AW-1:0] ana_fault_in,
	input  wire logic          cal_refreshed,
	input  wire logic          slew_busy,
	input  wire logic          wdt_expired,
	// Write one to clear strobes.
	input  wire logic          dig_clear_we,
	input  wire logic [DW-1:0] dig_clear_data,
	input  wire logic          ana_clear_we,
	input  wire logic [AW-1:0] ana_clear_data,
	// Fault line pin.
	input  wire logic          fault_line_in,
	output logic               fault_line_o,
	output logic               fault_line_oe,
	// Readback.
	output logic [DW-1:0]      digital_error_flags,
	output logic [AW-1:0]      analog_error_flags,
	output logic [1:0]         trip_limit_sel,
	output logic               digital_flags_summary,
	output logic               analog_flags_summary,
	output logic               watchdog_expired_summary,
	output logic               fault_pin_mirror
);

	// Returns the limit in degrees for a trip code.
	function automatic int trip_limit(input logic [1:0] code);
		unique case (code)
			FFAGG_TRIP_142: trip_limit = FFAGG_LIMIT_142_C;
			FFAGG_TRIP_127: trip_limit = FFAGG_LIMIT_127_C;
			FFAGG_TRIP_112: trip_limit = FFAGG_LIMIT_112_C;
			FFAGG_TRIP_97:  trip_limit = FFAGG_LIMIT_97_C;
		endcase
	endfunction

	// Sticky update: set wins over a write one clear that re-evaluates.
	function automatic logic [15:0] sticky_next(input logic [15:0] cur, input logic [15:0] cond,
			input logic [15:0] clr);
		sticky_next = ((cur & ~clr) | cond);
	endfunction

	logic [AW-1:0] comp_raw;
	logic [AW-1:0] comp_sync;
	logic [AW-1:0] ana_cond;
	logic [DW-1:0] dig_cond;
	logic [AW-1:0] ana_q;
	logic [AW-1:0] ana_d;
	logic [DW-1:0] dig_q;
	logic [DW-1:0] dig_d;
	logic [1:0]    trip_q;
	logic [1:0]    trip_d;
	logic          drive_q;
	logic          drive_d;
	logic          mirror_q;
	logic          mirror_d;
	logic [DW-1:0] dig_line;
	logic [AW-1:0] ana_line;

	// Temperature comparators carry no enable; supply comparators wait for software.
	always_comb begin
		comp_raw = '0;
		comp_raw[FFAGG_A_DIE_MAIN] = temp_main_over;
		comp_raw[FFAGG_A_DIE_DCDC] = temp_dcdc_over;
		comp_raw[3:0] = supply_out_of_window;
	end

	ffagg_sync #(
		.W(AW)
	) u_sync (
		.clk_sys (clk_sys),
		.srst    (srst),
		.clk_en  (clk_en),
		.async_in(comp_raw),
		.sync_out(comp_sync)
	);

	always_comb begin
		ana_cond = ana_fault_in & ~FFAGG_ANA_COMP;
		ana_cond = ana_cond | (comp_sync & FFAGG_ANA_COMP & 16'h0030);
		if (comparator_enable) begin
			ana_cond = ana_cond | (comp_sync & 16'h000f);
		end
		dig_cond = dig_fault_in;
		dig_cond[FFAGG_D_SLEW_BUSY] = slew_busy;
		dig_cond[FFAGG_D_WDT] = dig_fault_in[FFAGG_D_WDT] | wdt_expired;
	end

	// Flag registers, trip latch and fault line drive.
	always_comb begin
		ana_d = ana_q;
		dig_d = dig_q;
		trip_d = trip_q;
		if (srst) begin
			ana_d = FFAGG_ANA_RST;
			dig_d = FFAGG_DIG_RST;
			trip_d = FFAGG_TRIP_RST;
		end else if (clk_en) begin
			trip_d = trip_select;
			ana_d = sticky_next(ana_q, ana_cond, ana_clear_we ? ana_clear_data : '0);
			dig_d = sticky_next(dig_q & ~FFAGG_DIG_SELF_CLR, dig_cond & ~FFAGG_DIG_SELF_CLR,
				dig_clear_we ? dig_clear_data : '0);
			dig_d[FFAGG_D_SLEW_BUSY] = slew_busy;
			dig_d[FFAGG_D_CAL_UNREF] = (dig_q[FFAGG_D_CAL_UNREF] & ~cal_refreshed)
				| dig_fault_in[FFAGG_D_CAL_UNREF];
		end
	end

	always_comb begin
		dig_line = dig_q & (FFAGG_DIG_FORCED | (FFAGG_DIG_MASKABLE & ~fault_mask_dig));
		if (serial_diag_quiet) begin
			dig_line[FFAGG_D_SCLK_CNT] = 1'b0;
		end
		ana_line = ana_q & (FFAGG_ANA_FORCED | (FFAGG_ANA_MASKABLE & ~fault_mask_ana));
		drive_d = drive_q;
		mirror_d = mirror_q;
		if (srst) begin
			drive_d = 1'b0;
			mirror_d = 1'b0;
		end else if (clk_en) begin
			drive_d = (|dig_line) | (|ana_line);
			mirror_d = ~fault_line_in;
		end
	end

	always_ff @(posedge clk_sys) begin
		ana_q <= ana_d;
		dig_q <= dig_d;
		trip_q <= trip_d;
		drive_q <= drive_d;
		mirror_q <= mirror_d;
	end

	assign fault_line_o = 1'b0;
	assign fault_line_oe = drive_q;
	assign digital_error_flags = dig_q;
	assign analog_error_flags = ana_q;
	assign trip_limit_sel = trip_q;
	assign digital_flags_summary = |(dig_q & ~(DW'(1) << FFAGG_D_SLEW_BUSY));
	assign analog_flags_summary = |ana_q;
	assign watchdog_expired_summary = dig_q[FFAGG_D_WDT];
	assign fault_pin_mirror = mirror_q;

endmodule
`default_nettype wire

//--- sim/ffagg_host_model.sv
// Host side of the wired fault line: pull-up resistor and level sensing.
`timescale 1ns/1ps
`default_nettype none
module ffagg_host_model (
	// Device pin and sensed wire level.
	input  wire logic fault_line_o,
	input  wire logic fault_line_oe,
	output logic      fault_line_in
);
	// A released line rises to the pull-up level.
	assign fault_line_in = !(fault_line_oe && !fault_line_o);
endmodule
`default_nettype wire

//--- sim/ffagg_core_properties.sv
// Port checker of the fault flag aggregator.
`timescale 1ns/1ps
`default_nettype none
module ffagg_core_checker
	import ffagg_pkg::*;
#(
	parameter int DW = 16,
	parameter int AW = 16
) (
	// Inputs of the block.
	input wire logic          clk_sys,
	input wire logic          srst,
	input wire logic          clk_en,
	input wire logic [1:0]    trip_select,
	input wire logic          serial_diag_quiet,
	input wire logic          comparator_enable,
	input wire logic [DW-1:0] fault_mask_dig,
	input wire logic [AW-1:0] fault_mask_ana,
	input wire logic          temp_main_over,
	input wire logic [AW-1:0] ana_fault_in,
	input wire logic          ana_clear_we,
	input wire logic [AW-1:0] ana_clear_data,
	input wire logic          fault_line_in,
	// Outputs of the block.
	input wire logic          fault_line_oe,
	input wire logic [DW-1:0] digital_error_flags,
	input wire logic [AW-1:0] analog_error_flags,
	input wire logic [1:0]    trip_limit_sel,
	input wire logic          digital_flags_summary,
	input wire logic          fault_pin_mirror
);
	logic live;
	// Set flags that the masks and the quiet bit still let onto the line.
	assign live = |(digital_error_flags & (FFAGG_DIG_FORCED | FFAGG_DIG_MASKABLE & ~fault_mask_dig)
		& ~(DW'(serial_diag_quiet) << FFAGG_D_SCLK_CNT))
		|| |(analog_error_flags & (FFAGG_ANA_FORCED | FFAGG_ANA_MASKABLE & ~fault_mask_ana));
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (srst);
	property p_line;
		clk_en |=> fault_line_oe == $past(live);
	endproperty
	a_line: assert property (p_line) else $error("fault line drive wrong");
	property p_mirror;
		clk_en |=> fault_pin_mirror == !$past(fault_line_in);
	endproperty
	a_mirror: assert property (p_mirror) else $error("mirror bit wrong");
	property p_trip;
		clk_en |=> trip_limit_sel == $past(trip_select);
	endproperty
	a_trip: assert property (p_trip) else $error("trip select not reported");
	property p_dsum;
		digital_flags_summary == |(digital_error_flags & ~(DW'(1) << FFAGG_D_SLEW_BUSY));
	endproperty
	a_dsum: assert property (p_dsum) else $error("digital summary wrong");
	property p_clear;
		clk_en && ana_clear_we && ana_clear_data[6] && !ana_fault_in[6] |=> !analog_error_flags[6];
	endproperty
	a_clear: assert property (p_clear) else $error("flag not cleared");
	property p_sticky;
		clk_en && analog_error_flags[6] && !(ana_clear_we && ana_clear_data[6]) |=> analog_error_flags[6];
	endproperty
	a_sticky: assert property (p_sticky) else $error("flag lost");
	property p_temp;
		(clk_en && temp_main_over) ##1 clk_en[*2] |=> analog_error_flags[FFAGG_A_DIE_MAIN];
	endproperty
	a_temp: assert property (p_temp) else $error("die flag not set");
	property p_off;
		(!comparator_enable)[*4] ##0 analog_error_flags[3:0] == 4'h0 |=> analog_error_flags[3:0] == 4'h0;
	endproperty
	a_off: assert property (p_off) else $error("disabled supply flag set");
	c_line: cover property ($rose(fault_line_oe));
	c_quiet: cover property (serial_diag_quiet && digital_error_flags[FFAGG_D_SCLK_CNT]);
	c_keep: cover property (ana_clear_we && ana_fault_in[6] && analog_error_flags[6]);
endmodule
`default_nettype wire

//--- sim/tb_top.sv
// Testbench of the fault flag aggregator with a host on the wired fault line.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import ffagg_pkg::*;
	logic        clk_sys = 1'b0;
	logic        srst    = 1'b1;
	logic        comp_en = 1'b0;
	logic        quiet   = 1'b0;
	logic        cal_ref = 1'b0;
	logic        slew    = 1'b0;
	logic        clr_we  = 1'b0;
	logic        en      = 1'b1;
	logic        wdt     = 1'b0;
	logic        wsum;
	logic [1:0]  trip    = 2'h0;
	logic [31:0] stim    = 32'h0;
	logic [31:0] mask    = 32'h0;
	logic [31:0] clr     = 32'h0;
	logic [15:0] dflags, aflags;
	logic [1:0]  trip_q;
	logic        fl_o, oe, line_in, dsum, asum, mirror;
	int          n_mismatch = 0;
	int          compares   = 0;
	always #20 clk_sys = !clk_sys;
	ffagg_core u_ffagg_core (.clk_sys(clk_sys), .srst(srst), .clk_en(en), .trip_select(trip),
		.serial_diag_quiet(quiet), .comparator_enable(comp_en), .fault_mask_dig(mask[15:0]),
		.fault_mask_ana(mask[31:16]), .temp_main_over(stim[20]), .temp_dcdc_over(stim[21]),
		.supply_out_of_window(stim[19:16]), .dig_fault_in(stim[15:0]), .ana_fault_in(stim[31:16]),
		.cal_refreshed(cal_ref), .slew_busy(slew), .wdt_expired(wdt), .dig_clear_we(clr_we),
		.dig_clear_data(clr[15:0]), .ana_clear_we(clr_we), .ana_clear_data(clr[31:16]),
		.fault_line_in(line_in), .fault_line_o(fl_o), .fault_line_oe(oe), .digital_error_flags(dflags),
		.analog_error_flags(aflags), .trip_limit_sel(trip_q), .digital_flags_summary(dsum),
		.analog_flags_summary(asum), .watchdog_expired_summary(wsum), .fault_pin_mirror(mirror));
	ffagg_host_model u_ffagg_host_model (.fault_line_o(fl_o), .fault_line_oe(oe), .fault_line_in(line_in));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wipe(input logic [31:0] c);
		{clr, clr_we} = {c, 1'b1};
		@(negedge clk_sys);
		{cal_ref, clr_we} = 2'h0;
		@(negedge clk_sys);
	endtask
	task automatic t_first;
		chk({aflags, dflags}, {16'h0, FFAGG_DIG_RST});
		chk({oe, mirror, trip_q}, 4'h0);
		{stim[19:16], slew} = 5'h1f;
		wipe(32'h1 << FFAGG_D_RESET_DET);
		repeat (4) @(negedge clk_sys);
		chk({aflags, dflags, dsum}, 33'h4000);
		{comp_en, slew, stim} = {2'b10, 32'h4f0000};
		repeat (6) @(negedge clk_sys);
		chk({aflags, dflags, oe}, 33'h9e0001);
		wipe(32'h4f0000);
		chk({aflags, dflags}, 32'h4f0000);
		stim = 32'h0;
		repeat (3) @(negedge clk_sys);
		wipe(32'h4f0000);
		chk({aflags, dflags}, 32'h0);
	endtask
	task automatic hit(input int i, input logic m, input logic q);
		logic [31:0] fv;
		logic [31:0] mv;
		fv = {FFAGG_ANA_FORCED, FFAGG_DIG_FORCED & ~(16'h1 << (q ? FFAGG_D_SCLK_CNT : 16))};
		mv = {FFAGG_ANA_MASKABLE, FFAGG_DIG_MASKABLE};
		{mask, quiet, trip, stim[i]} = {{32{m}}, q, i[1:0], 1'b1};
		@(negedge clk_sys);
		stim[i] = 1'b0;
		repeat (5) @(negedge clk_sys);
		chk({aflags, dflags}, 32'h1 << i);
		chk({oe, mirror, dsum, asum}, {{2{fv[i] || mv[i] && !m}}, i < 16, i > 15});
		chk(trip_q, i[1:0]);
		cal_ref = (i == FFAGG_D_CAL_UNREF);
		wipe(32'h1 << i);
		chk({aflags, dflags}, 32'h0);
		@(negedge clk_sys);
		chk({oe, mirror}, 2'h0);
	endtask
	task automatic t_hold;
		{mask, en, stim[3]} = {32'h0, 2'b01};
		repeat (3) @(negedge clk_sys);
		stim[3] = 1'b0;
		chk({dflags, oe}, 17'h0);
		{en, wdt} = 2'b11;
		@(negedge clk_sys);
		wdt = 1'b0;
		repeat (2) @(negedge clk_sys);
		chk({dflags, oe, wsum, dsum}, {16'h0010, 3'h7});
		wipe(32'h10);
		chk({dflags, wsum}, 17'h0);
		@(negedge clk_sys);
	endtask
	task automatic give_verdict;
		$display("Comparisons %0d, mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	initial begin
		repeat (3) @(negedge clk_sys);
		srst = 1'b0;
		@(negedge clk_sys);
		t_first();
		for (int i = 0; i < 27; i++) begin
			for (int k = 0; k < 4; k++) begin
				if (i < 13 || i > 15) begin
					hit(i, k[0], k[1]);
				end
			end
		end
		t_hold();
		give_verdict();
	end
endmodule
bind ffagg_core ffagg_core_checker #(.DW(DW), .AW(AW)) u_ffagg_core_checker (.clk_sys(clk_sys), .srst(srst),
	.clk_en(clk_en), .trip_select(trip_select), .serial_diag_quiet(serial_diag_quiet),
	.comparator_enable(comparator_enable), .fault_mask_dig(fault_mask_dig), .fault_mask_ana(fault_mask_ana),
	.temp_main_over(temp_main_over), .ana_fault_in(ana_fault_in), .ana_clear_we(ana_clear_we),
	.ana_clear_data(ana_clear_data), .fault_line_in(fault_line_in), .fault_line_oe(fault_line_oe),
	.digital_error_flags(digital_error_flags), .analog_error_flags(analog_error_flags),
	.trip_limit_sel(trip_limit_sel), .digital_flags_summary(digital_flags_summary),
	.fault_pin_mirror(fault_pin_mirror));
`default_nettype wire
